//--- core/lpm_pkg.sv
// Shared constants for the low-power mode controller: register map,
// field positions, reset values and the mode enumeration.
// Assumes a 32-bit AXI4-Lite register bus and a single 200 MHz clock.
package lpm_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_SYSTEM_CONTROL_ONE = 12'h000;
  localparam logic [11:0] OFS_SYSTEM_CONTROL_TWO = 12'h004;
  localparam logic [11:0] OFS_MODE_STATUS = 12'h008;
  localparam int ADDR_W = 12;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  // system_control_one
  localparam int STANDBY_SELECT_POS = 7;
  localparam int STANDBY_WAIT_LSB = 4;
  localparam int STANDBY_WAIT_W = 3;
  // system_control_two
  localparam int SUBSLEEP_SELECT_POS = 7;
  localparam int LOW_SPEED_ON_POS = 6;
  localparam int DIRECT_TRANSITION_POS = 5;
  localparam int ACTIVE_FREQ_LSB = 2;
  localparam int ACTIVE_FREQ_W = 3;
  localparam int SUBACTIVE_DIV_LSB = 0;
  localparam int SUBACTIVE_DIV_W = 2;
  // mode_status
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_MODE_W = 4;
  localparam int STATUS_SYS_OSC_POS = 4;
  localparam int STATUS_OSC_STABLE_POS = 5;

  // ------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------
  localparam logic [7:0] SYSTEM_CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] SYSTEM_CONTROL_TWO_RST = 8'h00;
  localparam logic [1:0] SUBDIV_BY8 = 2'h0;
  localparam logic [1:0] SUBDIV_BY4 = 2'h1;
  localparam logic [1:0] SUBDIV_BY2 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [19:0] WAIT_ONE = 20'h00001;

  // Operating modes of the device
  typedef enum logic [3:0] {
    MODE_ACTIVE,
    MODE_SUBACTIVE,
    MODE_SLEEP,
    MODE_SUBSLEEP,
    MODE_STANDBY,
    MODE_OSC_WAIT,
    MODE_RESET_HOLD,
    MODE_RESET_SETTLE
  } mode_e;

endpackage : lpm_pkg

//--- core/low_power_mode_controller.sv
// Low-power mode controller: decodes the sleep target, halts or keeps CPU,
// clocks, ports and peripherals, and sequences wake-up and pin reset.
// Assumes sleep_req, interrupt and mask inputs come from logic on clk;
// reset_pin_n and osc_stable come from outside and are synchronised here.
//
// How it works
// - Sleep halts CPU, peripherals keep active clock
// - Pending interrupt ends sleep, starts exception
// - Masked or disabled interrupt keeps sleep
// - Sleep exit to active or subactive by bit
// - Reset pin low in sleep resets CPU
// - Standby stops clock generator, CPU, peripherals
// - Standby puts port outputs in high impedance
// - Standby wake waits selected time, then exception
// - Masked or disabled interrupt keeps standby
// - Stable clock plus pin high starts reset
// - Subsleep stops everything except timekeeping timer
// - Subsleep keeps port states as before
// - Subsleep wake to active or subactive
// - Subactive clock is watch clock over 2/4/8
// - Subactive sleep reaches any mode by settings
// - Transition with subsleep select resets peripherals
// - System oscillator only in active and sleep; also on in osc wait and reset states
// - Retained peripheral registers reachable in subactive
// - Target mode decoded from four select bits
// - Divider 00 by8, 01 by4, 1x by2
`timescale 1ns/100ps
module low_power_mode_controller #(
  parameter int IRQ_N = 8,
  parameter logic [19:0] STBY_WAIT_STEP = 20'h02000
) (
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [lpm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lpm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU and interrupt side
  input wire logic sleep_req,
  input wire logic cpu_imask,
  input wire logic [IRQ_N-1:0] irq_req,
  input wire logic [IRQ_N-1:0] irq_enable,
  input wire logic direct_irq_enable,
  // Pins and oscillator
  input wire logic reset_pin_n,
  input wire logic osc_stable,
  // Controls
  output logic cpu_halt,
  output logic cpu_reset,
  output logic irq_exception_start,
  output logic reset_exception_start,
  output logic cpu_on_subclock,
  output logic sys_osc_en,
  output logic sub_osc_en,
  output logic periph_clk_en,
  output logic timer_a_clk_en,
  output logic periph_reg_access_en,
  output logic periph_reset,
  output logic port_hiz,
  output logic port_hold,
  output logic [2:0] active_freq_sel,
  output logic [1:0] subclk_div_exp
);
  import lpm_pkg::*;

  // ------------------------------------------------------------
  // Registers and internal signals
  // ------------------------------------------------------------
  logic [7:0] ctrl_one_r;
  logic [7:0] ctrl_two_r;
  mode_e mode_r;
  mode_e mode_nxt;
  mode_e target_r;
  mode_e wake_mode_r;
  logic sub_sel_latched_r;
  logic [19:0] wait_cnt_r;
  logic pin_meta_r;
  logic pin_sync_r;
  logic osc_meta_r;
  logic osc_sync_r;
  logic wake;
  logic halted;
  mode_e sleep_target;
  mode_e exit_mode;
  logic [19:0] wait_len;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Two flops for each asynchronous input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= reset_pin_n;
      pin_sync_r <= pin_meta_r;
      osc_meta_r <= osc_stable;
      osc_sync_r <= osc_meta_r;
    end
  end

  // ------------------------------------------------------------
  // Target decode
  // ------------------------------------------------------------
  // Wake request: enabled interrupt with CPU mask clear
  assign wake = (|(irq_req & irq_enable)) && !cpu_imask;
  assign halted = (mode_r == MODE_SLEEP) || (mode_r == MODE_SUBSLEEP) || (mode_r == MODE_STANDBY);
  assign exit_mode = ctrl_two_r[LOW_SPEED_ON_POS] ? MODE_SUBACTIVE : MODE_ACTIVE;
  assign wait_len = 20'(({17'h0, ctrl_one_r[STANDBY_WAIT_LSB +: STANDBY_WAIT_W]} + WAIT_ONE) * STBY_WAIT_STEP);

  // Mode reached by a sleep instruction from the four select bits
  always_comb begin
    sleep_target = MODE_SLEEP;
    if (ctrl_two_r[DIRECT_TRANSITION_POS] && direct_irq_enable && !cpu_imask) begin
      sleep_target = exit_mode;
    end else if (ctrl_one_r[STANDBY_SELECT_POS] && !ctrl_two_r[DIRECT_TRANSITION_POS]) begin
      sleep_target = MODE_STANDBY;
    end else if (ctrl_two_r[SUBSLEEP_SELECT_POS]) begin
      sleep_target = MODE_SUBSLEEP;
    end else begin
      sleep_target = MODE_SLEEP;
    end
  end

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  // Next mode
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_ACTIVE, MODE_SUBACTIVE: begin
        if (sleep_req) begin
          mode_nxt = sleep_target;
        end
      end
      MODE_SLEEP, MODE_SUBSLEEP: begin
        if (wake) begin
          mode_nxt = wake_mode_r;
        end
      end
      MODE_STANDBY: begin
        if (wake) begin
          mode_nxt = MODE_OSC_WAIT;
        end
      end
      MODE_OSC_WAIT: begin
        if (wait_cnt_r == 20'h00000) begin
          mode_nxt = MODE_ACTIVE;
        end
      end
      MODE_RESET_HOLD: begin
        if (pin_sync_r) begin
          mode_nxt = MODE_RESET_SETTLE;
        end
      end
      MODE_RESET_SETTLE: begin
        if (!pin_sync_r) begin
          mode_nxt = MODE_RESET_HOLD;
        end else if (osc_sync_r) begin
          mode_nxt = MODE_ACTIVE;
        end
      end
      default: begin
        mode_nxt = MODE_RESET_HOLD;
      end
    endcase
    if (!pin_sync_r) begin
      mode_nxt = MODE_RESET_HOLD;
    end
  end

  // Mode register; reset pin enters the reset hold state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_RESET_HOLD;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Target and wake mode captured at the sleep instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_r <= MODE_ACTIVE;
      wake_mode_r <= MODE_ACTIVE;
      sub_sel_latched_r <= 1'b0;
    end else if ((mode_r == MODE_ACTIVE || mode_r == MODE_SUBACTIVE) && sleep_req) begin
      target_r <= sleep_target;
      wake_mode_r <= exit_mode;
      sub_sel_latched_r <= ctrl_two_r[SUBSLEEP_SELECT_POS];
    end
  end

  // Standby wake wait counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt_r <= 20'h00000;
    end else if (mode_r == MODE_STANDBY) begin
      wait_cnt_r <= wait_len - WAIT_ONE;
    end else if (mode_r == MODE_OSC_WAIT && wait_cnt_r != 20'h00000) begin
      wait_cnt_r <= wait_cnt_r - WAIT_ONE;
    end
  end

  // ------------------------------------------------------------
  // Control outputs
  // ------------------------------------------------------------
  // Exception starts and peripheral reset pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_exception_start <= 1'b0;
      reset_exception_start <= 1'b0;
      periph_reset <= 1'b0;
    end else begin
      irq_exception_start <= ((mode_r == MODE_SLEEP || mode_r == MODE_SUBSLEEP) && mode_nxt == wake_mode_r)
        || (mode_r == MODE_OSC_WAIT && mode_nxt == MODE_ACTIVE)
        || ((mode_r == MODE_ACTIVE || mode_r == MODE_SUBACTIVE) && sleep_req
            && (sleep_target == MODE_ACTIVE || sleep_target == MODE_SUBACTIVE));
      reset_exception_start <= (mode_r == MODE_RESET_SETTLE) && (mode_nxt == MODE_ACTIVE);
      periph_reset <= (mode_nxt != mode_r) && (mode_r != MODE_RESET_HOLD) && (mode_r != MODE_RESET_SETTLE)
        && (ctrl_two_r[SUBSLEEP_SELECT_POS] || (halted && sub_sel_latched_r));
    end
  end

  // Clock, CPU and port controls derived from the next mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt <= 1'b1;
      cpu_reset <= 1'b1;
      cpu_on_subclock <= 1'b0;
      sys_osc_en <= 1'b1;
      sub_osc_en <= 1'b1;
      periph_clk_en <= 1'b0;
      timer_a_clk_en <= 1'b0;
      periph_reg_access_en <= 1'b0;
      port_hiz <= 1'b0;
      port_hold <= 1'b0;
    end else begin
      cpu_halt <= !(mode_nxt == MODE_ACTIVE || mode_nxt == MODE_SUBACTIVE);
      cpu_reset <= (mode_nxt == MODE_RESET_HOLD) || (mode_nxt == MODE_RESET_SETTLE);
      cpu_on_subclock <= (mode_nxt == MODE_SUBACTIVE);
      sys_osc_en <= (mode_nxt == MODE_ACTIVE) || (mode_nxt == MODE_SLEEP) || (mode_nxt == MODE_OSC_WAIT)
        || (mode_nxt == MODE_RESET_HOLD) || (mode_nxt == MODE_RESET_SETTLE);
      sub_osc_en <= 1'b1;
      periph_clk_en <= (mode_nxt == MODE_ACTIVE) || (mode_nxt == MODE_SLEEP) || (mode_nxt == MODE_SUBACTIVE);
      timer_a_clk_en <= (mode_nxt != MODE_STANDBY) && (mode_nxt != MODE_OSC_WAIT)
        && (mode_nxt != MODE_RESET_HOLD) && (mode_nxt != MODE_RESET_SETTLE);
      periph_reg_access_en <= (mode_nxt == MODE_ACTIVE) || (mode_nxt == MODE_SUBACTIVE);
      port_hiz <= (mode_nxt == MODE_STANDBY) || (mode_nxt == MODE_OSC_WAIT);
      port_hold <= (mode_nxt == MODE_SLEEP) || (mode_nxt == MODE_SUBSLEEP);
    end
  end

  // Operating frequencies change only at a sleep instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_freq_sel <= SYSTEM_CONTROL_TWO_RST[ACTIVE_FREQ_LSB +: ACTIVE_FREQ_W];
      subclk_div_exp <= 2'h3;
    end else if ((mode_r == MODE_ACTIVE || mode_r == MODE_SUBACTIVE) && sleep_req) begin
      active_freq_sel <= ctrl_two_r[ACTIVE_FREQ_LSB +: ACTIVE_FREQ_W];
      case (ctrl_two_r[SUBACTIVE_DIV_LSB +: SUBACTIVE_DIV_W])
        SUBDIV_BY8: subclk_div_exp <= 2'h3;
        SUBDIV_BY4: subclk_div_exp <= 2'h2;
        default: subclk_div_exp <= 2'h1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // Write address and data taken in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end else if (aw_got_r && w_got_r) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (aw_got_r && w_got_r) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // Ready while the slot is empty and no response waits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // Register write and response
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_r <= SYSTEM_CONTROL_ONE_RST;
      ctrl_two_r <= SYSTEM_CONTROL_TWO_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (aw_got_r && w_got_r) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
        if (waddr_r == OFS_SYSTEM_CONTROL_ONE) begin
          if (wstrb_r[0]) begin
            ctrl_one_r <= wdata_r[7:0];
          end
        end else if (waddr_r == OFS_SYSTEM_CONTROL_TWO) begin
          if (wstrb_r[0]) begin
            ctrl_two_r <= wdata_r[7:0];
          end
        end else if (waddr_r != OFS_MODE_STATUS) begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        case (s_axi_araddr)
          OFS_SYSTEM_CONTROL_ONE: s_axi_rdata <= {24'h000000, ctrl_one_r};
          OFS_SYSTEM_CONTROL_TWO: s_axi_rdata <= {24'h000000, ctrl_two_r};
          OFS_MODE_STATUS: begin
            s_axi_rdata[STATUS_MODE_LSB +: STATUS_MODE_W] <= mode_r;
            s_axi_rdata[STATUS_SYS_OSC_POS] <= sys_osc_en;
            s_axi_rdata[STATUS_OSC_STABLE_POS] <= osc_sync_r;
          end
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sleep_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_SLEEP && !wake && pin_sync_r) |=> (mode_r == MODE_SLEEP))
    else $error("sleep left without wake");
  sleep_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_SLEEP && wake && pin_sync_r) |=> irq_exception_start && !cpu_halt)
    else $error("sleep wake did not start exception");
  standby_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_STANDBY && !wake && pin_sync_r) |=> (mode_r == MODE_STANDBY) && port_hiz)
    else $error("standby left without wake");
  standby_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_STANDBY) |-> port_hiz && !periph_clk_en && !sys_osc_en)
    else $error("standby ports or clocks wrong");
  osc_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_SUBACTIVE || mode_r == MODE_SUBSLEEP) |-> !sys_osc_en && sub_osc_en)
    else $error("system oscillator running in sub mode");
  pin_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!reset_pin_n && mode_r == MODE_SLEEP) ##1 !reset_pin_n |-> ##[1:2] cpu_reset)
    else $error("reset pin did not reset cpu");
  reset_exc_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(reset_exception_start) |-> $past(osc_sync_r) && $past(pin_sync_r) && !cpu_reset)
    else $error("reset exception without stable clock");
  target_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    halted && $past(halted) |-> $stable(target_r) && $stable(wake_mode_r))
    else $error("target changed while halted");
  subsleep_select_bit_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_ACTIVE && sleep_req && ctrl_two_r[SUBSLEEP_SELECT_POS] && pin_sync_r
     && sleep_target != MODE_ACTIVE) |=> periph_reset)
    else $error("peripheral reset missing");
  subsleep_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_r == MODE_SUBSLEEP) |-> port_hold && !port_hiz && timer_a_clk_en && !periph_clk_en)
    else $error("subsleep controls wrong");

endmodule : low_power_mode_controller

//--- verification/cpu_irq_model.sv
// CPU core and interrupt controller model facing the mode controller.
// Assumes the bench calls its tasks; every change lands just after a rising clk edge.
`timescale 1ns/100ps
module cpu_irq_model (
  input wire logic clk,
  output logic sleep_req,
  output logic cpu_imask,
  output logic [7:0] irq_req,
  output logic [7:0] irq_enable,
  output logic direct_irq_enable,
  output logic reset_pin_n,
  output logic osc_stable
);
  // Quiet lines, pin high, oscillator settled at time zero
  initial begin
    sleep_req = 1'b0;
    cpu_imask = 1'b0;
    irq_req = 8'h00;
    irq_enable = 8'h00;
    direct_irq_enable = 1'b0;
    reset_pin_n = 1'b1;
    osc_stable = 1'b1;
  end
  // One-cycle sleep instruction pulse
  task sleep_insn();
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
  endtask : sleep_insn
  // Level request on line 0 with its mask, enable and direct enable
  task irq(input logic m, input logic e, input logic r, input logic d);
    @(posedge clk);
    cpu_imask <= m;
    irq_enable <= {7'h00, e};
    irq_req <= {7'h00, r};
    direct_irq_enable <= d;
  endtask : irq
  // Pin low while the oscillator restarts; released only once it is stable
  task pin_reset(input int hold);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    osc_stable <= 1'b0;
    repeat (hold) @(posedge clk);
    osc_stable <= 1'b1;
    repeat (4) @(posedge clk);
    reset_pin_n <= 1'b1;
  endtask : pin_reset
endmodule : cpu_irq_model

//--- verification/low_power_mode_controller_tb.sv
// Self-checking bench for the low-power mode controller.
// Assumes the partner model drives the CPU side; the bench is the AXI4-Lite master.
`timescale 1ns/100ps
module low_power_mode_controller_tb;
  import lpm_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic sleep_req, cpu_imask, direct_irq_enable, reset_pin_n, osc_stable;
  logic [7:0] irq_req, irq_enable;
  logic cpu_halt, cpu_reset, irq_exception_start, reset_exception_start, cpu_on_subclock, sys_osc_en, sub_osc_en;
  logic periph_clk_en, timer_a_clk_en, periph_reg_access_en, periph_reset, port_hiz, port_hold;
  logic [2:0] active_freq_sel;
  logic [1:0] subclk_div_exp;
  int errors = 0, checked = 0, irq_cnt = 0, rst_cnt = 0, prst_cnt = 0, n, p0, k;
  // ----------------------------------------
  // Clock, instances, pulse counters
  // ----------------------------------------
  always #2.5 clk = ~clk;
  low_power_mode_controller #(.IRQ_N(8), .STBY_WAIT_STEP(20'h00004)) u_low_power_mode_controller (.clk, .rst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_req, .cpu_imask, .irq_req, .irq_enable, .direct_irq_enable,
    .reset_pin_n, .osc_stable, .cpu_halt, .cpu_reset, .irq_exception_start, .reset_exception_start,
    .cpu_on_subclock, .sys_osc_en, .sub_osc_en, .periph_clk_en, .timer_a_clk_en, .periph_reg_access_en,
    .periph_reset, .port_hiz, .port_hold, .active_freq_sel, .subclk_div_exp);
  cpu_irq_model u_cpu_irq_model (.clk, .sleep_req, .cpu_imask, .irq_req, .irq_enable, .direct_irq_enable,
    .reset_pin_n, .osc_stable);
  // Count one-cycle pulses so no pulse is missed between checks
  always @(posedge clk) begin
    if (irq_exception_start === 1'b1) irq_cnt <= irq_cnt + 1;
    if (reset_exception_start === 1'b1) rst_cnt <= rst_cnt + 1;
    if (periph_reset === 1'b1) prst_cnt <= prst_cnt + 1;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // Write with both channels offered together, bready held until bvalid
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin do @(posedge clk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
      begin do @(posedge clk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
    join
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task rdr(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  task mode(input mode_e m);
    rdr(OFS_MODE_STATUS);
    chk(rd & 32'h0000000F, {28'h0, m}, "mode code");
  endtask : mode
  // Wait a bounded time for the next exception pulse, then one more edge
  task wake(input int n0);
    for (k = 0; k < 200 && irq_cnt == n0; k++) @(posedge clk);
    @(posedge clk);
    chk(irq_cnt, n0 + 1, "exception pulse");
  endtask : wake
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs();
    rdr(OFS_SYSTEM_CONTROL_ONE);
    chk(rd, 32'h0, "sys1 reset value");
    wr(OFS_SYSTEM_CONTROL_TWO, 32'hFFFFFF5A);
    rdr(OFS_SYSTEM_CONTROL_TWO);
    chk(rd, 32'h0000005A, "sys2 readback");
    wr(12'h00C, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    rdr(12'h00C);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(OFS_MODE_STATUS, 32'h7);
    mode(MODE_ACTIVE);
    $display("test regs done");
  endtask : t_regs
  task t_sleep();
    wr(OFS_SYSTEM_CONTROL_ONE, 32'h0);
    wr(OFS_SYSTEM_CONTROL_TWO, 32'h14);
    p0 = prst_cnt;
    u_cpu_irq_model.sleep_insn();
    repeat (2) @(posedge clk);
    chk({cpu_halt, periph_clk_en, port_hold, active_freq_sel}, {3'b111, 3'h5}, "sleep outputs");
    mode(MODE_SLEEP);
    u_cpu_irq_model.irq(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    chk(cpu_halt, 1'b1, "masked wake");
    u_cpu_irq_model.irq(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    chk(cpu_halt, 1'b1, "disabled wake");
    n = irq_cnt;
    u_cpu_irq_model.irq(1'b0, 1'b1, 1'b1, 1'b0);
    wake(n);
    chk({cpu_halt, cpu_on_subclock, sys_osc_en, port_hold}, 4'b0010, "sleep exit");
    chk(prst_cnt, p0, "no peripheral reset");
    u_cpu_irq_model.irq(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test sleep done");
  endtask : t_sleep
  task t_subsleep();
    wr(OFS_SYSTEM_CONTROL_TWO, 32'hC1);
    p0 = prst_cnt;
    u_cpu_irq_model.sleep_insn();
    repeat (2) @(posedge clk);
    chk({cpu_halt, periph_clk_en, timer_a_clk_en, port_hold, port_hiz, sys_osc_en, sub_osc_en}, 7'b1011001,
      "subsleep outputs");
    mode(MODE_SUBSLEEP);
    n = irq_cnt;
    u_cpu_irq_model.irq(1'b0, 1'b1, 1'b1, 1'b0);
    wake(n);
    chk({cpu_halt, cpu_on_subclock, periph_reg_access_en, sys_osc_en, subclk_div_exp}, 6'b011010,
      "subactive");
    chk(prst_cnt, p0 + 2, "peripheral resets");
    u_cpu_irq_model.irq(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test subsleep done");
  endtask : t_subsleep
  task t_standby();
    wr(OFS_SYSTEM_CONTROL_ONE, 32'hA0);
    wr(OFS_SYSTEM_CONTROL_TWO, 32'h02);
    p0 = prst_cnt;
    u_cpu_irq_model.sleep_insn();
    repeat (2) @(posedge clk);
    chk({cpu_halt, periph_clk_en, port_hiz, sys_osc_en}, 4'b1010, "standby outputs");
    chk(subclk_div_exp, 2'h1, "divide by two");
    mode(MODE_STANDBY);
    u_cpu_irq_model.irq(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    chk(port_hiz, 1'b1, "masked standby");
    n = irq_cnt;
    u_cpu_irq_model.irq(1'b0, 1'b1, 1'b1, 1'b0);
    for (k = 0; k < 200 && irq_cnt == n; k++) @(posedge clk);
    chk(k >= 12 && k <= 16, 1'b1, "standby wait span");
    @(posedge clk);
    chk({cpu_halt, cpu_on_subclock, port_hiz}, 3'b000, "standby exit");
    chk(prst_cnt, p0, "no stale reset");
    u_cpu_irq_model.irq(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test standby done");
  endtask : t_standby
  task t_direct();
    wr(OFS_SYSTEM_CONTROL_ONE, 32'h0);
    wr(OFS_SYSTEM_CONTROL_TWO, 32'h60);
    u_cpu_irq_model.irq(1'b0, 1'b0, 1'b0, 1'b1);
    n = irq_cnt;
    u_cpu_irq_model.sleep_insn();
    wake(n);
    chk({cpu_halt, cpu_on_subclock, subclk_div_exp}, 4'b0111, "direct to subactive");
    wr(OFS_SYSTEM_CONTROL_TWO, 32'h20);
    n = irq_cnt;
    u_cpu_irq_model.sleep_insn();
    wake(n);
    chk({cpu_halt, cpu_on_subclock}, 2'b00, "direct to active");
    u_cpu_irq_model.irq(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test direct done");
  endtask : t_direct
  task t_pinrst();
    wr(OFS_SYSTEM_CONTROL_TWO, 32'h0);
    u_cpu_irq_model.sleep_insn();
    n = rst_cnt;
    fork
      u_cpu_irq_model.pin_reset(20);
    join_none
    repeat (8) @(posedge clk);
    chk({cpu_reset, cpu_halt}, 2'b11, "pin reset in sleep");
    for (k = 0; k < 200 && rst_cnt == n; k++) @(posedge clk);
    chk(reset_pin_n, 1'b1, "reset start after pin high");
    chk(rst_cnt, n + 1, "reset exception");
    @(posedge clk);
    chk({cpu_reset, cpu_halt}, 2'b00, "out of reset");
    $display("test pin reset done");
  endtask : t_pinrst
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 200 && rst_cnt == 0; k++) @(posedge clk);
    chk(rst_cnt, 1, "power-on reset exception");
    t_regs();
    t_sleep();
    t_subsleep();
    t_standby();
    t_direct();
    t_pinrst();
    results();
  end
  initial begin
    #100000;
    errors++;
    results();
  end
endmodule : low_power_mode_controller_tb
